/* File: osc_ctl_map.svh */
// Purpose: register map, field positions, reset values and counts
// Assumes: 32-bit APB data, one aligned word per register
// Notes:   definitions only
`ifndef OSC_CTL_MAP_SVH
`define OSC_CTL_MAP_SVH
// ---------------------------------------------------------------
// register byte addresses
// ---------------------------------------------------------------
`define OFS_CONTROL 12'h000
`define OFS_STATUS 12'h004
`define OFS_TUNING 12'h008
// ---------------------------------------------------------------
// field positions and reset values
// ---------------------------------------------------------------
`define CTL_PLL_BIT 7
`define CTL_FREQ_HI 6
`define CTL_FREQ_LO 3
`define CTL_SRC_HI 1
`define CTL_SRC_LO 0
`define CTL_RESET 8'h38
`define CTL_WMASK 8'hfb
`define TUN_WMASK 8'h3f
`define TUN_RESET 8'h00
// ---------------------------------------------------------------
// configured oscillator mode codes
// ---------------------------------------------------------------
`define MODE_LP 3'h0
`define MODE_XT 3'h1
`define MODE_HS 3'h2
`define MODE_RC 3'h3
`define MODE_INT 3'h4
// ---------------------------------------------------------------
// counts
// ---------------------------------------------------------------
`define OST_COUNT 1024
`define FSM_DIV 64
`endif

/* File: osc_ctl_pkg.sv */
// Purpose: types shared by the oscillator control block
// Assumes: nothing
// Notes:   enums use gray codes along the usual path
package osc_ctl_pkg;
  // system clock source actually in use
  typedef enum logic [1:0] {
    SRC_CFG = 2'h0,
    SRC_T1 = 2'h1,
    SRC_INT = 2'h3
  } src_t;
  // start-up timer states
  typedef enum logic [1:0] {
    ST_COUNT = 2'h0,
    ST_DONE = 2'h1,
    ST_SLEEP = 2'h3
  } ost_t;
  // configuration straps
  typedef struct packed {
    logic fail_mon_on;
    logic two_speed_on;
    logic pll_force;
    logic [2:0] osc_mode;
  } cfg_t;
  // oscillator readiness pins
  typedef struct packed {
    logic hf_rdy;
    logic hf_lock;
    logic hf_stable;
    logic mf_rdy;
    logic lf_rdy;
    logic t1_en;
    logic t1_rdy;
    logic pll_lock;
  } osc_rdy_t;
endpackage : osc_ctl_pkg

/* File: oscillator_select_and_status.sv */
// Purpose: clock source select, start-up timer, fail-safe monitor
// Assumes: core_clk 10 MHz, APB slave with one wait state
// Notes:   oscillator pins and straps are synchronised here
//
// Decided for this implementation: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "osc_ctl_map.svh"

// Functional notes
// - fail monitor waits for start-up timer end
// - start-up timer runs after reset and wake
// - external clock and RC modes skip timer
// - fail monitor also forces two-speed start-up
// - pll force overrides software pll bit
// - low frequency codes pick lf or mf
// - high frequency codes use hf source
// - source field: internal, timer1, configured
// - control bit 2 reads zero
// - timer1 ready reads one when disabled
// - status bit 6 shows pll ready
// - status bit 5 shows configured source running
// - bits 4,2,1 show hf, mf, lf ready
// - bits 3 and 0 show hf accuracy
// - six-bit signed frequency trim
// - clock failure selects internal, raises flag
// - sample clock is lf divided by 64
// - reset, sleep, source change clear failure
// - crystal modes count 1024 oscillator cycles
module oscillator_select_and_status
  import osc_ctl_pkg::*;
#(
  parameter int OST_CYCLES = `OST_COUNT,
  parameter int SAMPLE_DIV = `FSM_DIV
)(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire cfg_t cfg_pins,
  input wire osc_rdy_t rdy_pins,
  input wire logic ext_osc_clk,
  input wire logic lf_osc_clk,
  input wire logic sleep_enter,
  input wire logic wake_up,
  output src_t sysclk_source_sel,
  output logic [3:0] int_freq_select,
  output logic pll_on,
  output logic [5:0] freq_trim,
  output logic clock_fail_flag,
  output logic cpu_hold
);
  localparam int OW = $clog2(OST_CYCLES);
  localparam int DW = $clog2(SAMPLE_DIV) - 1;
  localparam int SW = $bits(cfg_t) + $bits(osc_rdy_t) + 2;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [SW-1:0] pin_raw;
  logic [SW-1:0] meta_ff; // first stage, read only by second
  logic [SW-1:0] sync_ff; // clean copies
  assign pin_raw = {cfg_pins, rdy_pins, ext_osc_clk, lf_osc_clk};

  genvar gi;
  generate
    for (gi = 0; gi < SW; gi++)
    begin : g_sync
      // two flops per pin
      always_ff @(posedge core_clk)
      begin
        meta_ff[gi] <= nrst ? pin_raw[gi] : 1'b0;
        sync_ff[gi] <= nrst ? meta_ff[gi] : 1'b0;
      end
    end
  endgenerate

  cfg_t cfg; // synchronised straps
  osc_rdy_t rdy; // synchronised readiness
  logic ext_s; // external clock level
  logic lf_s; // low frequency clock level
  assign {cfg, rdy, ext_s, lf_s} = sync_ff;

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  logic [7:0] ctl_ff; // control register
  logic [7:0] tun_ff; // tuning register
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] prdata_ff;
  logic acc; // access phase, answer due
  logic hit_ctl;
  logic hit_sta;
  logic hit_tun;
  logic wr_ctl;
  logic wr_tun;
  logic [7:0] sta; // status assembled from hardware state
  logic [7:0] rd_byte;
  logic [1:0] new_src;
  logic src_chg; // write changes source field

  assign acc = psel & penable & ~pready_ff;
  assign hit_ctl = paddr == `OFS_CONTROL;
  assign hit_sta = paddr == `OFS_STATUS;
  assign hit_tun = paddr == `OFS_TUNING;
  assign wr_ctl = psel & penable & pready_ff & pwrite & hit_ctl;
  assign wr_tun = psel & penable & pready_ff & pwrite & hit_tun;
  assign rd_byte = hit_ctl ? ctl_ff :
                   hit_sta ? sta :
                   hit_tun ? tun_ff : 8'h00;
  assign new_src = pwdata[`CTL_SRC_HI:`CTL_SRC_LO];
  assign src_chg = wr_ctl & (new_src != ctl_ff[`CTL_SRC_HI:`CTL_SRC_LO]);

  // answer one cycle into the access phase
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end
    else
    begin
      pready_ff <= acc;
      pslverr_ff <= acc & ~(hit_ctl | hit_sta | hit_tun);
      prdata_ff <= acc ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  // control and tuning registers; status has no storage
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      ctl_ff <= `CTL_RESET;
      tun_ff <= `TUN_RESET;
    end
    else
    begin
      if (wr_ctl)
        ctl_ff <= pwdata[7:0] & `CTL_WMASK;
      if (wr_tun)
        tun_ff <= pwdata[7:0] & `TUN_WMASK;
    end
  end

  // ---------------------------------------------------------------
  // internal frequency decode
  // ---------------------------------------------------------------
  logic [3:0] fsel;
  logic fsel_lf;
  logic fsel_mf;
  logic int_rdy; // chosen internal source ready
  logic nxt_pll;
  assign fsel = ctl_ff[`CTL_FREQ_HI:`CTL_FREQ_LO];
  assign fsel_lf = fsel[3:1] == 3'h0;
  assign fsel_mf = (fsel == 4'h2) | (fsel[3:2] == 2'h1);
  // everything else comes from the high source
  assign int_rdy = fsel_lf ? rdy.lf_rdy :
                   fsel_mf ? rdy.mf_rdy : rdy.hf_rdy;
  assign nxt_pll = cfg.pll_force | ctl_ff[`CTL_PLL_BIT];

  // ---------------------------------------------------------------
  // start-up timer
  // ---------------------------------------------------------------
  ost_t st_ff;
  ost_t nxt_st;
  logic [OW-1:0] ost_ff;
  logic [OW-1:0] nxt_ost;
  logic ext_d_ff;
  logic ext_fall;
  logic crystal;
  logic skip_ost; // modes needing no start-up count
  assign ext_fall = ext_d_ff & ~ext_s;
  assign crystal = (cfg.osc_mode == `MODE_LP) |
                   (cfg.osc_mode == `MODE_XT) |
                   (cfg.osc_mode == `MODE_HS);
  assign skip_ost = ~crystal;

  // next state of the timer
  always_comb
  begin
    nxt_st = st_ff;
    nxt_ost = ost_ff;
    case (st_ff)
      ST_COUNT:
      begin
        if (skip_ost)
          nxt_st = ST_DONE;
        else if (ext_fall)
        begin
          if (ost_ff == OW'(OST_CYCLES - 1))
            nxt_st = ST_DONE;
          else
            nxt_ost = ost_ff + 1'b1;
        end
      end
      ST_DONE:
        nxt_st = ST_DONE;
      ST_SLEEP:
        nxt_st = ST_SLEEP;
      default:
        nxt_st = ST_COUNT;
    endcase
    if (sleep_enter)
      nxt_st = ST_SLEEP; // sleep aborts the count
    else if (wake_up | src_chg)
    begin
      nxt_st = ST_COUNT;
      nxt_ost = '0;
    end
    if (nxt_st != ST_COUNT)
      nxt_ost = '0;
  end

  // timer registers; reset restarts the count
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      st_ff <= ST_COUNT;
      ost_ff <= '0;
      ext_d_ff <= 1'b0;
    end
    else
    begin
      st_ff <= nxt_st;
      ost_ff <= nxt_ost;
      ext_d_ff <= ext_s;
    end
  end

  // ---------------------------------------------------------------
  // fail-safe monitor
  // ---------------------------------------------------------------
  logic [DW-1:0] div_ff; // lf edges per half sample cycle
  logic lf_d_ff;
  logic seen_ff; // external falling edge seen this half
  logic fail_ff; // fail-safe condition
  logic half_end;
  logic mon_on;
  logic fail_set;
  logic fail_clr;
  src_t cur_ff;
  assign half_end = lf_s & ~lf_d_ff & (div_ff == '1);
  assign mon_on = cfg.fail_mon_on & (st_ff == ST_DONE) &
                  (cur_ff != SRC_INT) & ~fail_ff;
  assign fail_set = mon_on & half_end & ~seen_ff & ~ext_fall;
  assign fail_clr = sleep_enter | src_chg;

  // divider, edge latch and failure flag
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      div_ff <= '0;
      lf_d_ff <= 1'b0;
      seen_ff <= 1'b0;
      fail_ff <= 1'b0;
    end
    else
    begin
      lf_d_ff <= lf_s;
      if (lf_s & ~lf_d_ff)
        div_ff <= div_ff + 1'b1;
      if (ext_fall)
        seen_ff <= 1'b1;
      else if (half_end)
        seen_ff <= 1'b0;
      fail_ff <= fail_set | (fail_ff & ~fail_clr);
    end
  end

  // ---------------------------------------------------------------
  // source selection
  // ---------------------------------------------------------------
  src_t tgt; // wanted source
  logic tgt_rdy;
  logic [1:0] scs;
  logic want_cfg; // configured oscillator asked for, no failure
  logic ost_done; // start-up count finished
  assign scs = ctl_ff[`CTL_SRC_HI:`CTL_SRC_LO];
  assign ost_done = st_ff == ST_DONE;
  assign want_cfg = (scs == 2'h0) & ~fail_ff &
                    (cfg.osc_mode != `MODE_INT);
  // run from the internal block while the start-up timer counts
  assign tgt = want_cfg ? (ost_done ? SRC_CFG : SRC_INT) :
               ((scs == 2'h1) & ~fail_ff) ? SRC_T1 : SRC_INT;
  assign tgt_rdy = (tgt == SRC_INT) ? int_rdy :
                   (tgt == SRC_T1) ? rdy.t1_rdy : ost_done;
  // fail monitor implies two-speed start-up
  logic two_speed;
  assign two_speed = cfg.two_speed_on | cfg.fail_mon_on;

  logic fail_p_ff;
  logic hold_ff;
  logic pll_ff;
  // switch only to a ready source
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      cur_ff <= SRC_INT;
      fail_p_ff <= 1'b0;
      hold_ff <= 1'b0;
      pll_ff <= 1'b0;
    end
    else
    begin
      if (tgt_rdy)
        cur_ff <= tgt;
      fail_p_ff <= fail_set;
      hold_ff <= crystal & ~two_speed & want_cfg & ~ost_done;
      pll_ff <= nxt_pll;
    end
  end

  // ---------------------------------------------------------------
  // status assembly, hardware only
  // ---------------------------------------------------------------
  assign sta = {
    ~rdy.t1_en | rdy.t1_rdy,
    pll_ff & rdy.pll_lock,
    cur_ff == SRC_CFG,
    rdy.hf_rdy,
    rdy.hf_lock,
    rdy.mf_rdy,
    rdy.lf_rdy,
    rdy.hf_stable
  };

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign sysclk_source_sel = cur_ff;
  assign int_freq_select = ctl_ff[`CTL_FREQ_HI:`CTL_FREQ_LO];
  assign pll_on = pll_ff;
  assign freq_trim = tun_ff[5:0];
  assign clock_fail_flag = fail_p_ff;
  assign cpu_hold = hold_ff;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  property p_bit2_zero;
    pready_ff && $past(hit_ctl) |-> prdata_ff[2] == 1'b0;
  endproperty
  a_bit2_zero: assert property (p_bit2_zero)
    else $error("control bit 2 read nonzero");

  property p_pll_force;
    cfg.pll_force |=> pll_on;
  endproperty
  a_pll_force: assert property (p_pll_force)
    else $error("pll off while forced");

  property p_fail_after_ost;
    $rose(fail_ff) |-> $past(st_ff) == ST_DONE;
  endproperty
  a_fail_after_ost: assert property (p_fail_after_ost)
    else $error("failure flagged before timer end");

  property p_skip;
    st_ff == ST_COUNT && skip_ost && !sleep_enter && !wake_up
      && !src_chg |=> st_ff == ST_DONE;
  endproperty
  a_skip: assert property (p_skip)
    else $error("timer not skipped");

  property p_wake;
    wake_up && !sleep_enter |=> st_ff == ST_COUNT && ost_ff == '0;
  endproperty
  a_wake: assert property (p_wake)
    else $error("timer not restarted on wake");

  property p_switch;
    cur_ff != $past(cur_ff) |-> $past(tgt_rdy);
  endproperty
  a_switch: assert property (p_switch)
    else $error("switched to unready source");

  property p_fail_pulse;
    fail_set |=> clock_fail_flag ##1 !clock_fail_flag;
  endproperty
  a_fail_pulse: assert property (p_fail_pulse)
    else $error("fail flag pulse wrong");

  property p_fail_int;
    fail_ff && int_rdy |=> sysclk_source_sel == SRC_INT;
  endproperty
  a_fail_int: assert property (p_fail_int)
    else $error("no internal switch after failure");

  property p_ost_end;
    st_ff == ST_COUNT && ost_ff == OW'(OST_CYCLES - 1) && ext_fall
      && !sleep_enter && !wake_up && !src_chg |=> st_ff == ST_DONE;
  endproperty
  a_ost_end: assert property (p_ost_end)
    else $error("timer did not end at full count");

  property p_no_hold;
    cfg.fail_mon_on |=> !cpu_hold;
  endproperty
  a_no_hold: assert property (p_no_hold)
    else $error("core held while two-speed forced");

  property p_sleep_clr;
    sleep_enter && !fail_set |=> !fail_ff;
  endproperty
  a_sleep_clr: assert property (p_sleep_clr)
    else $error("failure not cleared by sleep");
endmodule : oscillator_select_and_status

/* File: tb_top.sv */
// Purpose: self-checking bench for oscillator_select_and_status
// Assumes: apb master waits for pready, short timer and divider
// Notes:   oscillator pins are modelled as slow toggles off core_clk
`timescale 1ns/1ps
module tb_top;
  import osc_ctl_pkg::*;
  // one table row: write flag, address, data, expected data, error
  typedef struct packed {
    logic w;
    logic [11:0] a;
    logic [31:0] d;
    logic [31:0] x;
    logic e;
  } row_t;
  logic core_clk = 1'b0;
  logic nrst = 1'b0; // synchronous, active low
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  cfg_t cfg_pins = 6'h05; // external clock mode, monitor off
  osc_rdy_t rdy_pins = 8'hff; // all sources ready
  logic ext_osc_clk = 1'b0;
  logic lf_osc_clk = 1'b0;
  logic sleep_enter = 1'b0;
  logic wake_up = 1'b0;
  logic ext_run = 1'b1; // external oscillator running
  src_t sysclk_source_sel;
  logic [3:0] int_freq_select;
  logic pll_on;
  logic [5:0] freq_trim;
  logic clock_fail_flag;
  logic cpu_hold;
  logic [1:0] ecnt = 2'h0;
  logic [1:0] lcnt = 2'h0;
  logic [31:0] rd;
  logic er;
  int bad_count = 0;
  int comparisons = 0;
  int cycles = 0;
  int fails = 0;
  row_t rows [10];
  osc_rdy_t pats [3];
  // ---------------------------------------------------------------
  // clock, oscillators and watchdog
  // ---------------------------------------------------------------
  always #50 core_clk = ~core_clk;
  // ext period 6 cycles, lf period 8 cycles, both slow enough to see
  always @(posedge core_clk)
  begin
    cycles++;
    ecnt <= (ecnt == 2'h2) ? 2'h0 : ecnt + 2'h1;
    if (ecnt == 2'h2 && ext_run)
      ext_osc_clk <= ~ext_osc_clk;
    lcnt <= lcnt + 2'h1;
    if (lcnt == 2'h3)
      lf_osc_clk <= ~lf_osc_clk;
    if (clock_fail_flag === 1'b1)
      fails++;
    if (cycles == 20000)
    begin
      bad_count++; // hang cut short
      final_report();
    end
  end
  oscillator_select_and_status #(.OST_CYCLES(8), .SAMPLE_DIV(8))
    oscillator_select_and_status_inst (
    .core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cfg_pins(cfg_pins),
    .rdy_pins(rdy_pins), .ext_osc_clk(ext_osc_clk),
    .lf_osc_clk(lf_osc_clk), .sleep_enter(sleep_enter),
    .wake_up(wake_up), .sysclk_source_sel(sysclk_source_sel),
    .int_freq_select(int_freq_select), .pll_on(pll_on),
    .freq_trim(freq_trim), .clock_fail_flag(clock_fail_flag),
    .cpu_hold(cpu_hold));
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  // one apb transfer: setup, access held until pready sampled high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge core_clk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // counted compare with immediate report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick
  // counts, verdict and end of run
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : final_report
  // status image from pins and pll state, running source bit 5 left zero
  function automatic logic [31:0] stat_exp(osc_rdy_t p, logic pll);
    return {24'h0, p.t1_rdy | ~p.t1_en, pll & p.pll_lock, 1'b0,
            p.hf_rdy, p.hf_lock, p.mf_rdy, p.lf_rdy, p.hf_stable};
  endfunction : stat_exp
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    rows[0] = '{1'b1, 12'h000, 32'hff, 32'h0, 1'b0};
    rows[1] = '{1'b0, 12'h000, 32'h0, 32'hfb, 1'b0};
    rows[2] = '{1'b1, 12'h008, 32'hff, 32'h0, 1'b0};
    rows[3] = '{1'b0, 12'h008, 32'h0, 32'h3f, 1'b0};
    rows[4] = '{1'b1, 12'h008, 32'h20, 32'h0, 1'b0};
    rows[5] = '{1'b0, 12'h008, 32'h0, 32'h20, 1'b0};
    rows[6] = '{1'b1, 12'h00c, 32'hff, 32'h0, 1'b1};
    rows[7] = '{1'b0, 12'h00c, 32'h0, 32'h0, 1'b1};
    rows[8] = '{1'b1, 12'h000, 32'h7a, 32'h0, 1'b0};
    rows[9] = '{1'b0, 12'h000, 32'h0, 32'h7a, 1'b0};
    pats[0] = 8'hff;
    pats[1] = 8'h54;
    pats[2] = 8'ha8;
    tick(4);
    nrst <= 1'b1;
    // table of register accesses
    foreach (rows[i])
    begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      chk(er, rows[i].e);
      if (!rows[i].w)
        chk(rd, rows[i].x);
    end
    chk(freq_trim, 6'h20);
    $display("test register table done");
    // every frequency code reaches the output
    for (int c = 0; c < 16; c++)
    begin
      apb(1'b1, 12'h000, {25'h0, c[3:0], 3'b010});
      tick(2);
      chk(int_freq_select, c[3:0]);
    end
    chk(sysclk_source_sel, SRC_INT);
    apb(1'b1, 12'h000, 32'h79);
    tick(8);
    chk(sysclk_source_sel, SRC_T1);
    // internal switch waits for the oscillator the code selects
    rdy_pins <= 8'h0f;
    tick(3);
    apb(1'b1, 12'h000, 32'h7a);
    tick(4);
    chk(sysclk_source_sel, SRC_T1);
    apb(1'b1, 12'h000, 32'h12);
    tick(4);
    chk(sysclk_source_sel, SRC_T1);
    apb(1'b1, 12'h000, 32'h0a);
    tick(4);
    chk(sysclk_source_sel, SRC_INT);
    rdy_pins <= 8'hff;
    apb(1'b1, 12'h000, 32'h78);
    tick(10);
    chk(sysclk_source_sel, SRC_CFG);
    $display("test frequency and source done");
    // software pll bit versus forced pll
    apb(1'b1, 12'h000, 32'h7a);
    tick(3);
    chk(pll_on, 1'b0);
    apb(1'b1, 12'h000, 32'hfa);
    tick(3);
    chk(pll_on, 1'b1);
    cfg_pins <= 6'h0d;
    apb(1'b1, 12'h000, 32'h7a);
    tick(5);
    chk(pll_on, 1'b1);
    cfg_pins <= 6'h05;
    apb(1'b1, 12'h000, 32'hfa);
    $display("test pll done");
    // status follows pins and ignores writes
    foreach (pats[i])
    begin
      rdy_pins <= pats[i];
      tick(6);
      apb(1'b1, 12'h004, 32'hff);
      apb(1'b0, 12'h004, 32'h0);
      chk(rd, stat_exp(pats[i], 1'b1));
    end
    rdy_pins <= 8'hff;
    $display("test status done");
    // fail monitor in external clock mode
    cfg_pins <= 6'h25;
    apb(1'b1, 12'h000, 32'h78);
    tick(100);
    chk(fails, 0);
    chk(sysclk_source_sel, SRC_CFG);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, stat_exp(8'hff, 1'b0) | 32'h20);
    ext_run <= 1'b0;
    for (int n = 0; n < 150 && fails == 0; n++)
      tick(1);
    chk(fails, 1);
    tick(4);
    chk(sysclk_source_sel, SRC_INT);
    ext_run <= 1'b1;
    tick(12);
    apb(1'b1, 12'h000, 32'h7a);
    apb(1'b1, 12'h000, 32'h78);
    tick(60);
    chk(sysclk_source_sel, SRC_CFG);
    $display("test fail monitor done");
    // start-up timer in crystal mode after sleep and wake
    cfg_pins <= 6'h21;
    ext_run <= 1'b0;
    tick(5);
    sleep_enter <= 1'b1;
    tick(1);
    sleep_enter <= 1'b0;
    tick(3);
    wake_up <= 1'b1;
    tick(1);
    wake_up <= 1'b0;
    tick(20);
    chk(sysclk_source_sel, SRC_INT);
    chk(cpu_hold, 1'b0);
    cfg_pins <= 6'h01;
    tick(5);
    chk(cpu_hold, 1'b1);
    ext_run <= 1'b1;
    tick(24);
    chk(sysclk_source_sel, SRC_INT);
    tick(60);
    chk(sysclk_source_sel, SRC_CFG);
    chk(cpu_hold, 1'b0);
    $display("test start-up timer done");
    // reset in mid-run restores defaults
    nrst <= 1'b0;
    tick(3);
    chk(sysclk_source_sel, SRC_INT);
    chk(int_freq_select, 4'h7);
    chk(freq_trim, 6'h00);
    chk(clock_fail_flag, 1'b0);
    chk(pll_on, 1'b0);
    chk(cpu_hold, 1'b0);
    tick(1);
    nrst <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h38);
    apb(1'b0, 12'h008, 32'h0);
    chk(rd, 32'h00);
    $display("test reset done");
    final_report();
  end
endmodule : tb_top
